// file: core/hid_divider.v
// apb register file and 8-cycle integer divider
`timescale 1ns/10ps
`include "hid_defs.vh"

module hid_divider #(
  parameter WIDTH = 32
) (
  input  wire             clock,
  input  wire             rst,
  input  wire             signed_mode,
  input  wire             psel,
  input  wire             penable,
  input  wire             pwrite,
  input  wire [11:0]      paddr,
  input  wire [31:0]      pwdata,
  output reg  [31:0]      prdata,
  output reg              pready,
  output reg              pslverr,
  output reg              irq
);

  // ----------------------------------------
  // registers
  // ----------------------------------------
  reg [WIDTH-1:0] dividend_operand;
  reg [WIDTH-1:0] divisor_operand;
  reg [WIDTH-1:0] quotient_result;
  reg [WIDTH-1:0] remainder_result;
  reg             calc_done_flag;
  reg             zero_divisor_flag;
  reg             busy;
  reg [3:0]       cycle_cnt;
  reg [1:0]       irq_status;
  reg [1:0]       irq_mask;
  reg             mode_q;
  reg [WIDTH-1:0] res_q;
  reg [WIDTH-1:0] res_r;
  reg             sync_a;
  reg             sync_b;

  wire wr_en = psel && penable && pwrite && !pready;
  wire rd_en = psel && penable && !pwrite && !pready;
  wire start = wr_en && (paddr == `HID_OFS_CTRL) && pwdata[`HID_BIT_START];
  wire finish = busy && (cycle_cnt == `HID_CALC_CYCLES - 4'h1);
  wire mapped = (paddr == `HID_OFS_CTRL) || (paddr == `HID_OFS_DVDND) ||
                (paddr == `HID_OFS_DVSR) || (paddr == `HID_OFS_QUOT) ||
                (paddr == `HID_OFS_REM) || (paddr == `HID_OFS_IRQ_ST) ||
                (paddr == `HID_OFS_IRQ_MSK);

  // ----------------------------------------
  // mode strap synchroniser
  // ----------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      sync_a <= 1'b0;
      sync_b <= 1'b0;
    end else begin
      sync_a <= signed_mode;
      sync_b <= sync_a;
    end
  end

  // ----------------------------------------
  // truncating division
  // ----------------------------------------
  // magnitudes divided unsigned, signs restored after; the operation is
  // combinational and the 8-cycle wait only paces when the result is published
  reg [WIDTH-1:0] mag_a;
  reg [WIDTH-1:0] mag_b;
  reg [WIDTH-1:0] uq;
  reg [WIDTH-1:0] ur;
  reg             neg_a;
  reg             neg_b;
  always @* begin
    neg_a = mode_q && dividend_operand[WIDTH-1];
    neg_b = mode_q && divisor_operand[WIDTH-1];
    mag_a = neg_a ? (~dividend_operand + 1'b1) : dividend_operand;
    mag_b = neg_b ? (~divisor_operand + 1'b1) : divisor_operand;
    if (mag_b == {WIDTH{1'b0}}) begin
      uq = {WIDTH{1'b1}};
      ur = mag_a;
    end else begin
      uq = mag_a / mag_b;
      ur = mag_a % mag_b;
    end
    // quotient sign is the xor of signs, remainder takes the dividend's sign
    res_q = (neg_a ^ neg_b) ? (~uq + 1'b1) : uq;
    res_r = neg_a ? (~ur + 1'b1) : ur;
  end

  // ----------------------------------------
  // sequencer and results
  // ----------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      busy              <= 1'b0;
      cycle_cnt         <= 4'h0;
      mode_q            <= 1'b0;
      calc_done_flag    <= `HID_RST_DONE;
      zero_divisor_flag <= 1'b0;
      quotient_result   <= `HID_RST_WORD;
      remainder_result  <= `HID_RST_WORD;
    end else begin
      if (start) begin
        busy              <= 1'b1;
        cycle_cnt         <= 4'h0;
        mode_q            <= sync_b;
        calc_done_flag    <= 1'b0;
        zero_divisor_flag <= 1'b0;
      end else if (finish) begin
        busy              <= 1'b0;
        calc_done_flag    <= 1'b1;
        zero_divisor_flag <= (divisor_operand == {WIDTH{1'b0}});
        quotient_result   <= res_q;
        remainder_result  <= res_r;
      end else if (busy) begin
        cycle_cnt <= cycle_cnt + 4'h1;
      end
    end
  end

  // ----------------------------------------
  // apb slave
  // ----------------------------------------
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      pready           <= 1'b0;
      pslverr          <= 1'b0;
      prdata           <= 32'h00000000;
      dividend_operand <= `HID_RST_WORD;
      divisor_operand  <= `HID_RST_WORD;
      irq_mask         <= 2'h0;
    end else begin
      pready  <= wr_en || rd_en;
      pslverr <= (wr_en || rd_en) && !mapped;
      if (wr_en && paddr == `HID_OFS_DVDND)
        dividend_operand <= pwdata;
      if (wr_en && paddr == `HID_OFS_DVSR)
        divisor_operand <= pwdata;
      if (wr_en && paddr == `HID_OFS_IRQ_MSK)
        irq_mask <= pwdata[1:0];
      if (rd_en) begin
        case (paddr)
          `HID_OFS_CTRL:    prdata <= {28'h0000000, calc_done_flag, zero_divisor_flag, 2'h0};
          `HID_OFS_DVDND:   prdata <= dividend_operand;
          `HID_OFS_DVSR:    prdata <= divisor_operand;
          `HID_OFS_QUOT:    prdata <= quotient_result;
          `HID_OFS_REM:     prdata <= remainder_result;
          `HID_OFS_IRQ_ST:  prdata <= {30'h00000000, irq_status};
          `HID_OFS_IRQ_MSK: prdata <= {30'h00000000, irq_mask};
          default:          prdata <= 32'h00000000;
        endcase
      end else begin
        prdata <= 32'h00000000;
      end
    end
  end

  // ----------------------------------------
  // interrupts
  // ----------------------------------------
  // a new event wins over a simultaneous write-one clear
  wire [1:0] irq_set = {finish && (divisor_operand == {WIDTH{1'b0}}), finish};
  wire [1:0] irq_clr = (wr_en && paddr == `HID_OFS_IRQ_ST) ? pwdata[1:0] : 2'h0;
  always @(posedge clock or posedge rst) begin
    if (rst) begin
      irq_status <= 2'h0;
      irq        <= 1'b0;
    end else begin
      irq_status <= (irq_status & ~irq_clr) | irq_set;
      irq        <= |(((irq_status & ~irq_clr) | irq_set) & irq_mask);
    end
  end

endmodule // hid_divider

// file: pkg/hid_defs.vh
// constants and register map of the hardware integer divider
`ifndef HID_DEFS_VH
`define HID_DEFS_VH

// ----------------------------------------
// register offsets
// ----------------------------------------
`define HID_OFS_CTRL    12'h000
`define HID_OFS_DVDND   12'h004
`define HID_OFS_DVSR    12'h008
`define HID_OFS_QUOT    12'h00c
`define HID_OFS_REM     12'h010
`define HID_OFS_IRQ_ST  12'h014
`define HID_OFS_IRQ_MSK 12'h018

// ----------------------------------------
// field positions and reset values
// ----------------------------------------
`define HID_BIT_START   0
`define HID_BIT_ZERO    2
`define HID_BIT_DONE    3
`define HID_IRQ_DONE    0
`define HID_IRQ_ZERO    1
`define HID_RST_DONE    1'b1
`define HID_RST_WORD    32'h00000000

// ----------------------------------------
// timing
// ----------------------------------------
`define HID_CALC_CYCLES 4'h8

`endif

// file: verification/hid_divider_chk.sv
// port checker for the integer divider
`timescale 1ns/10ps
module hid_divider_chk (
  input wire        clock, rst, signed_mode, psel, penable, pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata, prdata,
  input wire        pready, pslverr, irq
);
  wire       acc = psel && penable && !pready;
  wire       go  = acc && pwrite && paddr == 12'h000 && pwdata[0];
  reg  [3:0] cnt;
  // cycles left until the result lands; a start while busy reloads it
  always @(posedge clock or posedge rst)
    if (rst) cnt <= 4'h0;
    else if (go) cnt <= 4'h8;
    else if (cnt != 4'h0) cnt <= cnt - 4'h1;
  default clocking @(posedge clock); endclocking
  default disable iff (rst);
  ready_one_pulse_a: assert property (pready |=> !pready) else $error("long ready");
  ready_in_time_a: assert property (acc |=> pready) else $error("late ready");
  idle_data_zero_a: assert property (!pready |-> prdata == 32'h0) else $error("stray data");
  err_with_ready_a: assert property (pslverr |-> pready) else $error("stray error");
  unmapped_err_a: assert property (acc && paddr > 12'h018 |=> pslverr && prdata == 32'h0)
    else $error("unmapped not refused");
  mapped_ok_a: assert property (acc && paddr <= 12'h018 && paddr[1:0] == 2'b00 |=> !pslverr)
    else $error("mapped refused");
  done_flag_time_a: assert property (acc && !pwrite && paddr == 12'h000 |=>
    prdata[3] == ($past(cnt) == 4'h0)) else $error("done flag timing");
  // a status clear moves irq at its own taking edge, a mask write one edge later
  irq_fall_cause_a: assert property ($fell(irq) |-> $past(acc && pwrite) ||
    $past(acc && pwrite, 2)) else $error("irq fell alone");
  irq_rise_cause_a: assert property ($rose(irq) |-> $past(acc && pwrite) ||
    $past(acc && pwrite, 2) || $past(cnt) == 4'h1) else $error("irq rose alone");
endmodule // hid_divider_chk
bind hid_divider hid_divider_chk chk (.clock(clock), .rst(rst), .signed_mode(signed_mode),
  .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
  .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq));

// file: verification/hid_apb_master.sv
// apb master standing in for the processor core
`timescale 1ns/10ps
module hid_apb_master (
  input  wire        clock,
  input  wire [31:0] prdata,
  input  wire        pready, pslverr,
  output reg         psel, penable, pwrite,
  output reg  [11:0] paddr,
  output reg  [31:0] pwdata
);
  initial begin
    psel = 0; penable = 0; pwrite = 0; paddr = 0; pwdata = 0;
  end
  task xfer(input w, input [11:0] a, input [31:0] d, output [31:0] r, output e);
    begin
      @(posedge clock);
      psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
      @(posedge clock);
      penable <= 1'b1;
      @(posedge clock);
      while (pready !== 1'b1) @(posedge clock);
      r = prdata; e = pslverr;
      // released lines flip so stale values cannot pass for good ones
      psel <= 1'b0; penable <= 1'b0; paddr <= ~a; pwdata <= ~d;
    end
  endtask
endmodule // hid_apb_master

// file: verification/hardware_integer_divider_bench.sv
// self-checking bench for the integer divider
`timescale 1ns/10ps
module hardware_integer_divider_bench;
  reg         clock = 0, rst = 1, signed_mode = 0, s, e;
  wire        psel, penable, pwrite, pready, pslverr, irq;
  wire [11:0] paddr;
  wire [31:0] pwdata, prdata;
  reg  [31:0] r, a, b, qx, rx;
  integer     err_count = 0, num_checks = 0, cyc = 0, i;
  reg  [64:0] tc [0:4] = '{{1'b0, 32'd100, 32'd7}, {1'b0, 32'hffffffff, 32'd3},
    {1'b0, 32'd5, 32'd0}, {1'b1, -32'sd7, 32'd2}, {1'b1, 32'd7, -32'sd2}};
  hid_divider dut (.clock(clock), .rst(rst), .signed_mode(signed_mode), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  hid_apb_master m (.clock(clock), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata));
  initial begin
    forever #20 clock = ~clock;
  end
  always @(posedge clock) begin
    cyc = cyc + 1;
    if (cyc == 3000) begin
      err_count = err_count + 1;
      final_report;
    end
  end
  task chk(input [31:0] seen, input [31:0] exp);
    num_checks = num_checks + 1;
    if (seen !== exp) begin
      err_count = err_count + 1;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  task final_report;
    $display("checks %0d mismatches %0d", num_checks, err_count);
    if (err_count == 0 && num_checks > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task wr(input [11:0] ad, input [31:0] d);
    m.xfer(1'b1, ad, d, r, e);
  endtask
  task rd(input [11:0] ad, input [31:0] x);
    m.xfer(1'b0, ad, 32'h0, r, e);
    chk(r, x);
  endtask
  initial begin
    repeat (16) @(posedge clock);
    rst <= 1'b0;
    rd(12'h000, 32'h8);
    rd(12'h010, 32'h0);
    for (i = 0; i < 5; i = i + 1) begin
      {s, a, b} = tc[i];
      // a conditional with one unsigned branch would make the signed division unsigned
      if (s) begin
        qx = $signed(a) / $signed(b);
        rx = $signed(a) % $signed(b);
      end else begin
        qx = a / b;
        rx = a % b;
      end
      if (b == 0) rx = a;
      signed_mode <= s;
      wr(12'h004, a);
      wr(12'h008, b);
      rd(12'h008, b);
      wr(12'h000, 32'h1);
      rd(12'h000, 32'h0);
      repeat (10) @(posedge clock);
      rd(12'h000, b == 0 ? 32'hc : 32'h8);
      if (b != 0) rd(12'h00c, qx);
      rd(12'h010, rx);
      $display("division case %0d done", i);
    end
    wr(12'h00c, 32'h1234);
    rd(12'h00c, qx);
    wr(12'h000, 32'h0);
    rd(12'h000, 32'h8);
    m.xfer(1'b0, 12'h020, 32'h0, r, e);
    chk(e, 1);
    wr(12'h014, 32'h3);
    wr(12'h018, 32'h0);
    wr(12'h000, 32'h1);
    repeat (12) @(posedge clock);
    chk(irq, 0);
    wr(12'h018, 32'h1);
    repeat (2) @(posedge clock);
    chk(irq, 1);
    wr(12'h014, 32'h1);
    repeat (2) @(posedge clock);
    chk(irq, 0);
    $display("register and interrupt tests done");
    final_report;
  end
endmodule // hardware_integer_divider_bench
